// *** hw/canopen_nmt_guarding_emergency.sv ***
// Network state, drive coupling, guarding and emergency for a slave node
`timescale 1ns/1ps
`include "canopen_nmt_params.svh"
module canopen_nmt_guarding_emergency #(
  parameter int TICK_CYCLES = `MS_NS / `CLK_NS
) (
  input wire logic    clk,           // 40 MHz system clock
  input wire logic    rst_n,         // Async reset, active low
  input wire logic [6:0] nodeIdPin,  // Node address switches
  input wire logic    cfgDonePin,    // Address and bit rate set
  input wire logic    rxValid,       // Received frame strobe
  input wire logic [10:0] rxId,      // Received identifier
  input wire logic    rxRtr,         // Received remote request
  input wire logic [3:0] rxDlc,      // Received data length
  input wire logic [63:0] rxData,    // Received payload
  output logic        txValid,       // Frame offered
  output logic [10:0] txId,          // Frame identifier
  output logic [3:0]  txDlc,         // Frame data length
  output logic [63:0] txData,        // Frame payload
  input wire logic    txReady,       // Frame taken
  input wire logic    odWrite,       // Object write strobe
  input wire logic [15:0] odIndex,   // Object index
  input wire logic [15:0] odWrData,  // Object write value
  output logic [15:0] odRdData,      // Object read value
  input wire logic    devError,      // Device error event
  input wire logic [15:0] errCode,   // Profile error code
  input wire logic [7:0]  errReg,    // Error register
  input wire logic [15:0] errNumber, // Device error number
  input wire logic [7:0]  errLocation, // Error location
  input wire logic [15:0] opHours,   // Operating hours
  input wire logic [3:0]  driveState, // Drive profile state
  input wire logic    syncMode,      // Apply reference and send actual value on sync
  input wire logic [31:0] actualValue, // Actual value to send
  output canopen_nmt_pkg::nmt_state_t nmtState, // Network state
  output logic [15:0] ctrlWord,      // Accepted control word
  output logic        ctrlWordValid, // Control word pulse
  output logic [15:0] refValue,      // Applied reference
  output logic        refValid,      // Reference pulse
  output logic        faultReset,    // Error reset pulse
  output logic        driveHold,     // Disable operation pulse
  output logic        driveResume,   // Enable operation pulse
  output logic        nodeReset,     // Application reset pulse
  output logic        guardError     // Guarding error, sticky
);
  // Pins come from outside the clock domain: two flip-flops each
  logic [6:0]  nodeMeta_q;
  logic [6:0]  nodeSync_q;
  logic        cfgMeta_q;
  logic        cfgSync_q;

  localparam canopen_nmt_pkg::nmt_state_t
    PRE = canopen_nmt_pkg::NMT_PREOP;
  localparam canopen_nmt_pkg::nmt_state_t
    OPR = canopen_nmt_pkg::NMT_OPER;
  localparam canopen_nmt_pkg::nmt_state_t
    STP = canopen_nmt_pkg::NMT_STOP;

  nmt_link_if lk ();

  canopen_nmt_pkg::nmt_state_t state_q;
  canopen_nmt_pkg::nmt_state_t state_d;
  logic        bootSent_q;
  logic        toggle_q;
  logic        holdPend_q;
  logic        guardErr_q;
  logic [15:0] guardMs_q;
  logic [15:0] lifeFactor_q;
  logic [15:0] rdData_q;
  logic [15:0] ctrl_q;
  logic        ctrlValid_q;
  logic [15:0] ref_q;
  logic [15:0] refPend_q;
  logic        refValid_q;
  logic        faultRst_q;
  logic        hold_q;
  logic        resume_q;
  logic        nodeRst_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nodeMeta_q <= 7'h00;
      nodeSync_q <= 7'h00;
      cfgMeta_q  <= 1'b0;
      cfgSync_q  <= 1'b0;
    end else begin
      nodeMeta_q <= nodeIdPin;
      nodeSync_q <= nodeMeta_q;
      cfgMeta_q  <= cfgDonePin;
      cfgSync_q  <= cfgMeta_q;
    end
  end

  wire [6:0]  node   = nodeSync_q;
  wire        isOper = (state_q == OPR);
  wire        isStop = (state_q == STP);
  wire        dataRx = rxValid && !rxRtr;
  wire [7:0]  cmd    = rxData[7:0];
  wire [6:0]  target = rxData[14:8];

  // Identifiers of the predefined set
  wire [10:0] idNmt =
    canopen_nmt_pkg::cobId(`FC_NMT, `NODE_ALL);
  wire [10:0] idSync =
    canopen_nmt_pkg::cobId(`FC_EMCY, `SYNC_NODE);
  wire [10:0] idRpdo =
    canopen_nmt_pkg::cobId(`FC_RPDO1, node);
  wire [10:0] idGuard =
    canopen_nmt_pkg::cobId(`FC_GUARD, node);

  wire forMe = (target == `NODE_ALL) || (target == node);
  wire nmtRx = dataRx && (rxId == idNmt) && (rxDlc == `DLC_NMT);
  wire cmdGo      = nmtRx && forMe && (cmd == `CS_START);
  wire cmdStop    = nmtRx && forMe && (cmd == `CS_STOP);
  wire cmdPre     = nmtRx && forMe && (cmd == `CS_PREOP);
  wire cmdRstNode = nmtRx && forMe && (cmd == `CS_RESET_NODE);
  wire cmdRstComm = nmtRx && forMe && (cmd == `CS_RESET_COMM);
  wire anyReset   = cmdRstNode || cmdRstComm;

  wire syncRx   = dataRx && (rxId == idSync);
  wire rpdoRx   = dataRx && (rxId == idRpdo);
  wire pollRx   = rxValid && rxRtr && (rxId == idGuard);
  wire rpdoTake = rpdoRx && isOper;
  wire syncTake = syncRx && syncMode && isOper;
  wire expire   = lk.expire;

  // Only the fault, enabled and switched-on drive states react to commands
  wire drvFault = (driveState == `DRV_FAULT);
  wire drvEn    = (driveState == `DRV_ENABLED);
  wire drvOn    = (driveState == `DRV_SWITCHED_ON);
  wire doFault  = cmdGo && drvFault;
  wire doHold   = cmdStop && drvEn;
  wire doResume = cmdGo && holdPend_q && drvOn;

  // A device error in the expiry cycle loses its frame
  wire [63:0] devEmcy =
    {opHours, errLocation, errNumber, errReg, errCode};
  wire [63:0] guardEmcy =
    {opHours, `ERRLOC_GUARD, 16'h0000, errReg, `ERRCODE_GUARD};
  wire [6:0]  guardStat = isOper ? `GSTAT_OPER :
                          isStop ? `GSTAT_STOP :
                          `GSTAT_PREOP;

  wire wrGuard = odWrite && (odIndex == `IDX_GUARD_TIME);
  wire wrLife  = odWrite && (odIndex == `IDX_LIFE_FACTOR);
  wire [15:0] rdMux = (odIndex == `IDX_GUARD_TIME) ? guardMs_q :
                      (odIndex == `IDX_LIFE_FACTOR) ? lifeFactor_q :
                      16'h0000;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PRE: begin
        if (cmdGo) state_d = OPR;
        else if (cmdStop) state_d = STP;
      end
      OPR: begin
        if (cmdStop) state_d = STP;
        else if (cmdPre) state_d = PRE;
      end
      STP: begin
        if (cmdGo) state_d = OPR;
        else if (cmdPre) state_d = PRE;
      end
    endcase
    // Errors and resets override what the master asked for
    if (devError && isOper) state_d = PRE;
    if (expire || anyReset) state_d = PRE;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) state_q <= PRE;
    else state_q <= state_d;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) bootSent_q <= 1'b0;
    else if (anyReset) bootSent_q <= 1'b0;
    else if (lk.reqBoot) bootSent_q <= 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) toggle_q <= 1'b0;
    else if (anyReset) toggle_q <= 1'b0;
    else if (pollRx) toggle_q <= !toggle_q;
  end

  // Expiry beats a reset command in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) guardErr_q <= 1'b0;
    else if (expire) guardErr_q <= 1'b1;
    else if (anyReset) guardErr_q <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) holdPend_q <= 1'b0;
    else if (doHold) holdPend_q <= 1'b1;
    else if (doResume || anyReset) holdPend_q <= 1'b0;
    // Leaving on or enabled by another path cancels the resume
    else if (!drvOn && !drvEn) holdPend_q <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      guardMs_q    <= `GUARD_TIME_RST;
      lifeFactor_q <= `LIFE_FACTOR_RST;
    end else begin
      if (wrGuard) guardMs_q <= odWrData;
      if (wrLife) lifeFactor_q <= odWrData;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rdData_q <= 16'h0000;
    else rdData_q <= rdMux;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q      <= 16'h0000;
      ctrlValid_q <= 1'b0;
    end else begin
      ctrlValid_q <= rpdoTake;
      if (rpdoTake) ctrl_q <= rxData[15:0];
    end
  end

  // In sync mode the reference waits for the next sync frame
  wire        refNow = (rpdoTake && !syncMode) || syncTake;
  wire [15:0] refSrc = syncMode ? refPend_q : rxData[31:16];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_q      <= 16'h0000;
      refPend_q  <= 16'h0000;
      refValid_q <= 1'b0;
    end else begin
      refValid_q <= refNow;
      if (refNow) ref_q <= refSrc;
      if (rpdoTake) refPend_q <= rxData[31:16];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      faultRst_q <= 1'b0;
      hold_q     <= 1'b0;
      resume_q   <= 1'b0;
      nodeRst_q  <= 1'b0;
    end else begin
      faultRst_q <= doFault;
      hold_q     <= doHold;
      resume_q   <= doResume;
      nodeRst_q  <= cmdRstNode;
    end
  end

  assign lk.poll       = pollRx;
  assign lk.restart    = anyReset;
  assign lk.guardMs    = guardMs_q;
  assign lk.lifeFactor = lifeFactor_q;
  assign lk.reqBoot    = cfgSync_q && !bootSent_q;
  assign lk.reqEmcy    = expire || devError;
  assign lk.emcyData   = expire ? guardEmcy : devEmcy;
  assign lk.reqGuard   = pollRx;
  assign lk.guardByte  = {toggle_q, guardStat};
  assign lk.reqTpdo    = syncTake;
  assign lk.tpdoData   = actualValue;
  assign lk.nodeId     = node;

  assign nmtState      = state_q;
  assign odRdData      = rdData_q;
  assign ctrlWord      = ctrl_q;
  assign ctrlWordValid = ctrlValid_q;
  assign refValue      = ref_q;
  assign refValid      = refValid_q;
  assign faultReset    = faultRst_q;
  assign driveHold     = hold_q;
  assign driveResume   = resume_q;
  assign nodeReset     = nodeRst_q;
  assign guardError    = guardErr_q;

  life_guard #(.TICK_CYCLES(TICK_CYCLES)) u_guard (
    .clk   (clk),
    .rst_n (rst_n),
    .lk    (lk)
  );

  frame_sender u_send (
    .clk     (clk),
    .rst_n   (rst_n),
    .lk      (lk),
    .txValid (txValid),
    .txId    (txId),
    .txDlc   (txDlc),
    .txData  (txData),
    .txReady (txReady)
  );

  property p_err_drop;
    @(posedge clk) disable iff (!rst_n)
    devError && isOper |=> nmtState == PRE;
  endproperty
  a_err_drop: assert property (p_err_drop)
    else $error("device error left network operational");

  property p_rpdo_gate;
    @(posedge clk) disable iff (!rst_n)
    rpdoRx && !isOper |=> !ctrlWordValid;
  endproperty
  a_rpdo_gate: assert property (p_rpdo_gate)
    else $error("control word taken outside operational");

  property p_toggle;
    @(posedge clk) disable iff (!rst_n)
    pollRx |=> toggle_q != $past(toggle_q);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("guard reply bit seven did not toggle");
endmodule

// *** include/canopen_nmt_params.svh ***
// Constants for the CANopen network management, guarding and emergency block
// Behaviour
// - Send one empty boot frame after reset
// - Device error in Operational forces Pre-Operational
// - Leave error Pre-Operational only by start or stop command
// - Accept control words only while Operational
// - Start command in fault state resets error
// - Stop holds enabled drive; start re-enables it
// - Other drive states ignore network commands
// - Emergency payload: code, register, number, location, hours
// - Emergency on emergency identifier, eight bytes
// - Answer every guarding poll with network state
// - Missing poll within lifetime raises guarding error
// - Guard time is 16-bit milliseconds, master-written
// - Lifetime equals guard time times factor
// - Supervision starts at first guarding poll
// - Lifetime expiry: Pre-Operational, emergency location 91
// - Guard reply byte with toggling bit seven
// - Predefined default identifier set per function
// - Sync mode: latch reference, send actual value
// - Decode command byte; node zero means all
`ifndef CANOPEN_NMT_PARAMS_SVH
`define CANOPEN_NMT_PARAMS_SVH
`define CS_START        8'h01
`define CS_STOP         8'h02
`define CS_PREOP        8'h80
`define CS_RESET_NODE   8'h81
`define CS_RESET_COMM   8'h82
`define NODE_ALL        7'h00
`define FC_NMT          4'h0
`define FC_EMCY         4'h1
`define FC_TPDO1        4'h3
`define FC_RPDO1        4'h4
`define FC_SDO_TX       4'hb
`define FC_SDO_RX       4'hc
`define FC_GUARD        4'he
`define SYNC_NODE       7'h00
`define IDX_GUARD_TIME  16'h100c
`define IDX_LIFE_FACTOR 16'h100d
`define GUARD_TIME_RST  16'h0000
`define LIFE_FACTOR_RST 16'h0000
`define DLC_BOOT        4'h0
`define DLC_EMCY        4'h8
`define DLC_GUARD       4'h1
`define DLC_TPDO        4'h4
`define DLC_NMT         4'h2
`define GSTAT_PREOP     7'h7f
`define GSTAT_OPER      7'h05
`define GSTAT_STOP      7'h04
`define ERRLOC_GUARD    8'h5b
`define ERRCODE_GUARD   16'h0000
`define DRV_ENABLED     4'h4
`define DRV_SWITCHED_ON 4'h3
`define DRV_FAULT       4'h7
`define MS_NS           1000000
`define CLK_NS          25
`endif

// *** include/canopen_nmt_pkg.sv ***
// Types and identifier helper for the CANopen network management block
package canopen_nmt_pkg;
  typedef enum logic [2:0] {
    NMT_PREOP = 3'b001,
    NMT_OPER  = 3'b010,
    NMT_STOP  = 3'b100
  } nmt_state_t;
  typedef logic [10:0] cob_id_t;
  function automatic cob_id_t cobId(input logic [3:0] fc,
                                    input logic [6:0] node);
    return {fc, node};
  endfunction
endpackage

// *** include/nmt_link_if.sv ***
// Links the network core to its guard timer and frame sender
`timescale 1ns/1ps
interface nmt_link_if;
  logic        poll;
  logic        restart;
  logic        expire;
  logic [15:0] guardMs;
  logic [15:0] lifeFactor;
  logic        reqBoot;
  logic        reqEmcy;
  logic        reqGuard;
  logic        reqTpdo;
  logic [63:0] emcyData;
  logic [7:0]  guardByte;
  logic [31:0] tpdoData;
  logic [6:0]  nodeId;
  modport core  (output poll, restart, guardMs, lifeFactor, reqBoot,
                 reqEmcy, reqGuard, reqTpdo, emcyData, guardByte,
                 tpdoData, nodeId, input expire);
  modport guard (input poll, restart, guardMs, lifeFactor,
                 output expire);
  modport send  (input reqBoot, reqEmcy, reqGuard, reqTpdo, emcyData,
                 guardByte, tpdoData, nodeId);
endinterface

// *** hw/life_guard.sv ***
// Life guarding supervision timer with its millisecond divider
`timescale 1ns/1ps
`include "canopen_nmt_params.svh"
module life_guard #(
  parameter int TICK_CYCLES = `MS_NS / `CLK_NS
) (
  input wire logic    clk,   // System clock
  input wire logic    rst_n, // Async reset, active low
  nmt_link_if.guard   lk     // Poll, restart and expiry
);
  localparam int TW = $clog2(TICK_CYCLES);
  logic [TW-1:0] tickCnt_q;
  logic [31:0]   msCnt_q;
  logic          active_q;
  logic          expire_q;

  wire        tick = (tickCnt_q == TW'(TICK_CYCLES - 1));
  wire [31:0] limit = {16'h0000, lk.guardMs} *
                      {16'h0000, lk.lifeFactor};
  // A zero lifetime disables supervision, as the master expects
  wire        expireNow = active_q && (limit != 32'h0) &&
                          (msCnt_q >= limit) && !lk.poll;

  // Divider restarts with each poll so the window is exact to a cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) tickCnt_q <= '0;
    else if (lk.poll || tick) tickCnt_q <= '0;
    else tickCnt_q <= tickCnt_q + TW'(1);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) msCnt_q <= 32'h0;
    else if (lk.poll) msCnt_q <= 32'h0;
    else if (active_q && tick) msCnt_q <= msCnt_q + 32'h1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) active_q <= 1'b0;
    else if (lk.restart) active_q <= 1'b0;
    else if (lk.poll) active_q <= 1'b1;
    else if (expireNow) active_q <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) expire_q <= 1'b0;
    else expire_q <= expireNow && !lk.restart;
  end

  assign lk.expire = expire_q;

  property p_life_limit;
    @(posedge clk) disable iff (!rst_n)
    expire_q |-> ($past(msCnt_q) >= $past(limit)) && ($past(limit) != 0);
  endproperty
  a_life_limit: assert property (p_life_limit)
    else $error("guard expiry before lifetime elapsed");

  property p_poll_restart;
    @(posedge clk) disable iff (!rst_n)
    lk.poll && !lk.restart |=> active_q && (msCnt_q == 32'h0) && !expire_q;
  endproperty
  a_poll_restart: assert property (p_poll_restart)
    else $error("poll did not start supervision");
endmodule

// *** hw/frame_sender.sv ***
// Prioritised transmit of boot, emergency, guard and process frames
`timescale 1ns/1ps
`include "canopen_nmt_params.svh"
module frame_sender (
  input wire logic          clk,     // System clock
  input wire logic          rst_n,   // Async reset, active low
  nmt_link_if.send          lk,      // Frame requests and payloads
  output logic              txValid, // Frame offered to controller
  output logic [10:0]       txId,    // Frame identifier
  output logic [3:0]        txDlc,   // Frame data length
  output logic [63:0]       txData,  // Payload, byte 0 in bits 7:0
  input wire logic          txReady  // Controller takes the frame
);
  localparam int NSRC = 4;
  wire  [NSRC-1:0] req = {lk.reqTpdo, lk.reqGuard, lk.reqEmcy, lk.reqBoot};
  logic [NSRC-1:0] pend_q;
  logic [NSRC-1:0] grant;
  logic [63:0]     emcy_q;
  logic [7:0]      guard_q;
  logic [31:0]     tpdo_q;

  wire load = (|pend_q) && (!txValid || txReady);

  // Lower index wins; a new request in the grant cycle stays pending
  for (genvar i = 0; i < NSRC; i++) begin : g_src
    assign grant[i] = load && pend_q[i] &&
                      ((pend_q & NSRC'((1 << i) - 1)) == '0);
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) pend_q[i] <= 1'b0;
      else pend_q[i] <= req[i] | (pend_q[i] & ~grant[i]);
    end
  end

  wire [3:0]  nextFc   = grant[2] ? `FC_GUARD :
                         grant[3] ? `FC_TPDO1 : `FC_EMCY;
  wire [3:0]  nextDlc  = grant[0] ? `DLC_BOOT :
                         grant[1] ? `DLC_EMCY :
                         grant[2] ? `DLC_GUARD : `DLC_TPDO;
  wire [63:0] nextData = grant[1] ? emcy_q :
                         grant[2] ? {56'h0, guard_q} :
                         grant[3] ? {32'h0, tpdo_q} : 64'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      emcy_q  <= 64'h0;
      guard_q <= 8'h00;
      tpdo_q  <= 32'h0;
    end else begin
      if (lk.reqEmcy) emcy_q <= lk.emcyData;
      if (lk.reqGuard) guard_q <= lk.guardByte;
      if (lk.reqTpdo) tpdo_q <= lk.tpdoData;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) txValid <= 1'b0;
    else if (load) txValid <= 1'b1;
    else if (txReady) txValid <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txId   <= 11'h000;
      txDlc  <= 4'h0;
      txData <= 64'h0;
    end else if (load) begin
      txId   <= canopen_nmt_pkg::cobId(nextFc, lk.nodeId);
      txDlc  <= nextDlc;
      txData <= nextData;
    end
  end

  property p_hold;
    @(posedge clk) disable iff (!rst_n)
    txValid && !txReady |=> txValid && $stable(txId) && $stable(txData);
  endproperty
  a_hold: assert property (p_hold)
    else $error("frame changed before acceptance");

  property p_boot_id;
    @(posedge clk) disable iff (!rst_n)
    txValid && (txDlc == `DLC_BOOT) |->
      txId == canopen_nmt_pkg::cobId(`FC_EMCY, lk.nodeId);
  endproperty
  a_boot_id: assert property (p_boot_id)
    else $error("empty frame not on emergency identifier");

  property p_emcy_id;
    @(posedge clk) disable iff (!rst_n)
    txValid && (txDlc == `DLC_EMCY) |->
      txId == canopen_nmt_pkg::cobId(`FC_EMCY, lk.nodeId);
  endproperty
  a_emcy_id: assert property (p_emcy_id)
    else $error("eight byte frame not on emergency identifier");
endmodule

// *** testbench/nmt_master_model.sv ***
// Network master model: sends frames, takes the slave's frames
`timescale 1ns/1ps
module nmt_master_model (
  input  wire logic        clk,     // Clock
  input  wire logic        rst_n,   // Reset
  output logic             rxValid, // Frame strobe
  output logic [10:0]      rxId,    // Identifier
  output logic             rxRtr,   // Remote request
  output logic [3:0]       rxDlc,   // Length
  output logic [63:0]      rxData,  // Payload
  input  wire logic        txValid, // Frame offered
  input  wire logic [10:0] txId,    // Identifier
  input  wire logic [3:0]  txDlc,   // Length
  input  wire logic [63:0] txData,  // Payload
  output logic             txReady  // Frame taken
);
  logic [10:0] gotId;
  logic [3:0]  gotDlc;
  logic [63:0] gotData;
  int          gotCount;
  int          waits;
  int          slowWait = 0;
  initial begin
    rxValid = 1'b0;
    {rxId, rxRtr, rxDlc, rxData} = '0;
  end
  task automatic send(input logic [10:0] id, input logic rtr,
                      input logic [3:0] dlc, input logic [63:0] d);
    @(posedge clk);
    rxValid <= 1'b1;
    {rxId, rxRtr, rxDlc, rxData} <= {id, rtr, dlc, d};
    @(posedge clk);
    rxValid <= 1'b0;
    rxData  <= ~d; // Idle bus must not repeat the payload
  endtask
  // Holds the slave off for slowWait plus one cycles on every frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txReady  <= 1'b0;
      waits    <= 0;
      gotCount <= 0;
    end else if (txValid && txReady) begin
      {gotId, gotDlc, gotData} <= {txId, txDlc, txData};
      gotCount <= gotCount + 1;
      txReady  <= 1'b0;
      waits    <= 0;
    end else if (txValid) begin
      waits   <= waits + 1;
      txReady <= waits >= slowWait;
    end
  end
endmodule

// *** testbench/canopen_nmt_guarding_emergency_bench.sv ***
// Self-checking bench for the network management slave block
`timescale 1ns/1ps
`define CHK(what, exp, got) begin \
  checkCount++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("unexpected %s: expected %h, seen %h", what, exp, got); \
  end \
end
module canopen_nmt_guarding_emergency_bench;
  localparam logic [6:0] NID = 7'h05;
  logic        clk, rst_n, cfgDonePin, rxValid, rxRtr, txValid, txReady;
  logic        odWrite, devError, syncMode, ctrlWordValid, faultReset;
  logic        driveHold, driveResume, guardError;
  logic [6:0]  nodeIdPin;
  logic [10:0] rxId, txId;
  logic [3:0]  rxDlc, txDlc, driveState;
  logic [63:0] rxData, txData;
  logic [15:0] odIndex, odWrData, odRdData, errCode, errNumber, opHours;
  logic [15:0] ctrlWord;
  logic [7:0]  errReg, errLocation;
  logic [31:0] actualValue;
  canopen_nmt_pkg::nmt_state_t nmtState;
  int failures = 0;
  int checkCount = 0;
  int frames = 0;
  int cycles = 0;
  int pulse[4] = '{0, 0, 0, 0};
  nmt_master_model m (.clk, .rst_n, .rxValid, .rxId, .rxRtr, .rxDlc,
                      .rxData, .txValid, .txId, .txDlc, .txData, .txReady);
  canopen_nmt_guarding_emergency #(.TICK_CYCLES(20)) dut (
    .clk, .rst_n, .nodeIdPin, .cfgDonePin, .rxValid, .rxId, .rxRtr, .rxDlc,
    .rxData, .txValid, .txId, .txDlc, .txData, .txReady, .odWrite, .odIndex,
    .odWrData, .odRdData, .devError, .errCode, .errReg, .errNumber,
    .errLocation, .opHours, .driveState, .syncMode, .actualValue, .nmtState,
    .ctrlWord, .ctrlWordValid, .refValue(), .refValid(), .faultReset,
    .driveHold, .driveResume, .nodeReset(), .guardError);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Pulses last one cycle, so they are counted rather than sampled late
  always @(posedge clk) begin
    pulse[0] += int'(ctrlWordValid === 1'b1);
    pulse[1] += int'(faultReset === 1'b1);
    pulse[2] += int'(driveHold === 1'b1);
    pulse[3] += int'(driveResume === 1'b1);
    cycles++;
    if (cycles == 8000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d failures %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic nmt(input logic [7:0] cs, input logic [6:0] node);
    m.send(11'h000, 1'b0, 4'h2, {48'h0, 1'b0, node, cs});
    repeat (4) @(posedge clk);
  endtask
  task automatic odWr(input logic [15:0] idx, input logic [15:0] v);
    @(posedge clk);
    {odWrite, odIndex, odWrData} <= {1'b1, idx, v};
    @(posedge clk);
    odWrite <= 1'b0;
  endtask
  task automatic odRd(input logic [15:0] idx, input logic [15:0] v);
    odIndex <= idx;
    repeat (2) @(posedge clk);
    `CHK("object", v, odRdData)
  endtask
  task automatic waitFrame();
    frames++;
    for (int i = 0; i < 400 && m.gotCount < frames; i++) @(posedge clk);
    `CHK("frames", frames, m.gotCount)
  endtask
  task automatic poll(input logic [7:0] exp);
    m.send({4'he, NID}, 1'b1, 4'h1, 64'h0);
    waitFrame();
    `CHK("guard id", {4'he, NID}, m.gotId)
    `CHK("guard byte", exp, m.gotData[7:0])
  endtask
  initial begin
    {rst_n, cfgDonePin, odWrite, devError, odIndex, odWrData} = '0;
    {nodeIdPin, syncMode, driveState, actualValue} = {NID, 5'h12, 32'h1234};
    {errCode, errReg, errNumber} = {16'h2310, 8'h04, 16'h0021};
    {errLocation, opHours} = {8'h11, 16'h0123};
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    cfgDonePin <= 1'b1;
    waitFrame();
    `CHK("boot id", {4'h1, NID}, m.gotId)
    `CHK("boot dlc", 4'h0, m.gotDlc)
    odWr(16'h100c, 16'h0003);
    odWr(16'h100d, 16'h0002);
    odRd(16'h100c, 16'h0003);
    odRd(16'h100d, 16'h0002);
    m.send({4'h4, NID}, 1'b0, 4'h2, 64'h000f);
    nmt(8'h01, 7'h00);
    `CHK("ignored control", 0, pulse[0])
    `CHK("start all", canopen_nmt_pkg::NMT_OPER, nmtState)
    m.send({4'h4, NID}, 1'b0, 4'h2, 64'h000f);
    m.send(11'h080, 1'b0, 4'h0, 64'h0);
    waitFrame();
    `CHK("control", 16'h000f, ctrlWord)
    `CHK("control pulses", 1, pulse[0])
    `CHK("sync id", {4'h3, NID}, m.gotId)
    `CHK("sync value", 32'h1234, m.gotData[31:0])
    nmt(8'h02, NID);
    nmt(8'h01, NID);
    `CHK("holds", 0, pulse[2] + pulse[3])
    driveState <= 4'h4;
    nmt(8'h02, NID);
    `CHK("hold", 1, pulse[2])
    driveState <= 4'h3;
    nmt(8'h01, NID);
    `CHK("resume", 1, pulse[3])
    driveState <= 4'h7;
    nmt(8'h01, NID);
    `CHK("fault reset", 1, pulse[1])
    driveState <= 4'h2;
    devError <= 1'b1;
    @(posedge clk);
    devError <= 1'b0;
    waitFrame();
    `CHK("emcy id", {4'h1, NID}, m.gotId)
    `CHK("emcy dlc", 4'h8, m.gotDlc)
    `CHK("emcy", {16'h0123, 8'h11, 16'h21, 8'h04, 16'h2310}, m.gotData)
    `CHK("forced", canopen_nmt_pkg::NMT_PREOP, nmtState)
    nmt(8'h01, 7'h06);
    `CHK("held", canopen_nmt_pkg::NMT_PREOP, nmtState)
    `CHK("no supervision", 1'b0, guardError)
    nmt(8'h01, NID);
    m.slowWait = 3;
    poll(8'h05);
    poll(8'h85);
    nmt(8'h80, NID);
    poll(8'h7f);
    nmt(8'h01, NID);
    poll(8'h85);
    repeat (90) @(posedge clk);
    `CHK("early expiry", 1'b0, guardError)
    waitFrame();
    `CHK("guard location", 8'h5b, m.gotData[47:40])
    `CHK("guard error", 1'b1, guardError)
    `CHK("expired", canopen_nmt_pkg::NMT_PREOP, nmtState)
    wrap_up();
  end
endmodule
